/* rtl/sysopt_pkg.sv */
package sysopt_pkg;

	// register map, byte addresses on the APB
	localparam logic [7:0] CFG_OFFSET  = 8'h00;
	localparam logic [7:0] STAT_OFFSET = 8'h04;

	// option field positions inside the configuration word
	localparam int XTAL_BIT    = 0;
	localparam int OSCSTOP_BIT = 1;
	localparam int BAUDSRC_BIT = 2;
	localparam int WDRATE_BIT  = 3;
	localparam int LVMSTOP_BIT = 4;
	localparam int LVMRSTD_BIT = 5;
	localparam int LVMPWRD_BIT = 6;
	localparam int CFG_WIDTH   = 7;

	// status field positions
	localparam int STABLE_BIT  = 0;
	localparam int INSTOP_BIT  = 1;
	localparam int LVMON_BIT   = 2;

	localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h00;

	// stabilisation counts in external clock cycles
	localparam logic [12:0] STAB_XTAL_CYCLES = 13'h1000;
	localparam logic [12:0] STAB_EXT_CYCLES  = 13'h0010;

	// watchdog timeouts in oscillator output cycles
	localparam logic [17:0] WDOG_SHORT_CYCLES = 18'h0_1FF0;
	localparam logic [17:0] WDOG_LONG_CYCLES  = 18'h3_FFF0;

	// bus clock is a quarter of the oscillator output clock
	localparam logic [1:0] BUS_DIV_LAST = 2'h3;

	// clock monitor acceptance windows, in Hz
	localparam int XTAL_LOW_MIN_HZ  = 30000;
	localparam int XTAL_LOW_MAX_HZ  = 100000;
	localparam int XTAL_HIGH_MIN_HZ = 1000000;
	localparam int XTAL_HIGH_MAX_HZ = 8000000;
	localparam int EXT_MIN_HZ       = 60;
	localparam int EXT_MAX_HZ       = 32000000;

	typedef struct packed {
		logic lvm_power_down;
		logic lvm_reset_disable;
		logic lvm_stop_enable;
		logic watchdog_rate_select;
		logic serial_clock_select;
		logic osc_run_in_stop;
		logic crystal_enable;
	} cfg_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage : sysopt_pkg

/* rtl/sysopt_cfg.sv */
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module sysopt_cfg #(
	parameter logic [17:0] P_WDOG_SHORT = sysopt_pkg::WDOG_SHORT_CYCLES,
	parameter logic [17:0] P_WDOG_LONG  = sysopt_pkg::WDOG_LONG_CYCLES
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_STOP_MODE,
	input  wire logic        I_INT_CLK_EN,
	input  wire logic        I_EXT_CLK_PIN,
	input  wire logic        I_EXT_GEN_ON,
	input  wire logic        I_SEL_EXT,
	input  wire logic        I_WDOG_SERVICE,
	input  wire logic        I_LVM_RESET_REQ,
	output logic             O_PIN_CRYSTAL,
	output logic             O_MON_XTAL_RANGE,
	output logic             O_INT_CLK_EN,
	output logic             O_EXT_CLK_EN,
	output logic             O_EXT_STABLE,
	output logic             O_OSC_OUT_EN,
	output logic             O_BUS_CLK_EN,
	output logic             O_BAUD_CLK_EN,
	output logic             O_WDOG_TIMEOUT,
	output logic             O_LVM_ACTIVE,
	output logic             O_SYS_RESET_REQ
);

	sysopt_pkg::cfg_t     cfg_q;
	sysopt_pkg::apb_req_t req;
	logic [31:0]          rdata_q;
	logic                 ext_s1_q;
	logic                 ext_s2_q;
	logic                 ext_s3_q;
	logic                 ext_edge;
	logic                 clk_allowed;
	logic                 ext_gen_eff;
	logic [12:0]          stab_cnt_q;
	logic [12:0]          stab_limit;
	logic                 stable_q;
	logic                 osc_tick;
	logic [1:0]           bus_div_q;
	logic [17:0]          wd_cnt_q;
	logic [17:0]          wd_limit;
	logic                 wd_timeout_q;
	logic                 cfg_wr;
	logic                 addr_cfg;
	logic                 addr_stat;

	// address decode, used by both the data path and the error answer
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE, paddr: I_PADDR, pwdata: I_PWDATA};
	assign addr_cfg  = hit(req.paddr, sysopt_pkg::CFG_OFFSET);
	assign addr_stat = hit(req.paddr, sysopt_pkg::STAT_OFFSET);
	assign cfg_wr    = req.psel && req.penable && req.pwrite && addr_cfg;

	// zero wait states; writes to status or unmapped space answer with an error
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = req.psel && req.penable && !(addr_cfg || (addr_stat && !req.pwrite));
	assign O_PRDATA  = rdata_q;

	// option register, cleared by reset
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			cfg_q <= sysopt_pkg::cfg_t'(sysopt_pkg::CFG_RESET);
		end else if (cfg_wr) begin
			cfg_q <= sysopt_pkg::cfg_t'(req.pwdata[sysopt_pkg::CFG_WIDTH-1:0]);
		end
	end

	// read data captured in the setup phase so it leaves a flop
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			rdata_q <= 32'h0000_0000;
		end else if (req.psel && !req.penable) begin
			rdata_q <= 32'h0000_0000;
			if (addr_cfg) begin
				rdata_q[sysopt_pkg::CFG_WIDTH-1:0] <= cfg_q;
			end else if (addr_stat) begin
				rdata_q[sysopt_pkg::STABLE_BIT] <= stable_q;
				rdata_q[sysopt_pkg::INSTOP_BIT] <= I_STOP_MODE;
				rdata_q[sysopt_pkg::LVMON_BIT]  <= O_LVM_ACTIVE;
			end
		end
	end

	// decoded option outputs straight from the register
	assign O_PIN_CRYSTAL    = cfg_q.crystal_enable;
	assign O_MON_XTAL_RANGE = cfg_q.crystal_enable;

	// external clock pin: two-flop synchroniser, third flop for the edge
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= I_EXT_CLK_PIN;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	assign ext_edge = ext_s2_q && !ext_s3_q;

	// stop mode gates every clock unless run-in-stop is chosen
	assign clk_allowed  = !I_STOP_MODE || cfg_q.osc_run_in_stop;
	assign ext_gen_eff  = I_EXT_GEN_ON && clk_allowed;
	assign O_INT_CLK_EN = I_INT_CLK_EN && clk_allowed;
	assign O_EXT_CLK_EN = ext_edge && ext_gen_eff;

	// crystal needs the long settle, a driven clock only the short one
	assign stab_limit = cfg_q.crystal_enable ? sysopt_pkg::STAB_XTAL_CYCLES
	                                         : sysopt_pkg::STAB_EXT_CYCLES;

	// stabilisation divider restarts whenever the generator is off or stopped
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || !ext_gen_eff) begin
			stab_cnt_q <= 13'h0000;
		end else if (O_EXT_CLK_EN && stab_cnt_q < stab_limit) begin
			stab_cnt_q <= stab_cnt_q + 13'h0001;
		end
	end

	// stable flag, dropped with the generator
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || !ext_gen_eff) begin
			stable_q <= 1'b0;
		end else if (stab_cnt_q >= stab_limit) begin
			stable_q <= 1'b1;
		end
	end
	assign O_EXT_STABLE = stable_q;

	// external source only once it has settled, else internal
	assign osc_tick     = (I_SEL_EXT && stable_q) ? O_EXT_CLK_EN : O_INT_CLK_EN;
	assign O_OSC_OUT_EN = osc_tick;

	// bus clock: every fourth oscillator tick
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			bus_div_q <= 2'h0;
		end else if (osc_tick) begin
			bus_div_q <= bus_div_q + 2'h1;
		end
	end
	assign O_BUS_CLK_EN  = osc_tick && (bus_div_q == sysopt_pkg::BUS_DIV_LAST);
	assign O_BAUD_CLK_EN = cfg_q.serial_clock_select ? O_BUS_CLK_EN : osc_tick;

	// watchdog counts oscillator cycles; short period with the select set
	assign wd_limit = cfg_q.watchdog_rate_select ? P_WDOG_SHORT : P_WDOG_LONG;

	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || I_WDOG_SERVICE) begin
			wd_cnt_q     <= 18'h0_0000;
			wd_timeout_q <= 1'b0;
		end else begin
			wd_timeout_q <= 1'b0;
			if (osc_tick) begin
				if (wd_cnt_q >= wd_limit - 18'h0_0001) begin
					wd_cnt_q     <= 18'h0_0000;
					wd_timeout_q <= 1'b1;
				end else begin
					wd_cnt_q <= wd_cnt_q + 18'h0_0001;
				end
			end
		end
	end
	assign O_WDOG_TIMEOUT = wd_timeout_q;

	// monitor power; power-down overrides the stop-mode enable
	assign O_LVM_ACTIVE = !I_STOP_MODE || (cfg_q.lvm_stop_enable && !cfg_q.lvm_power_down);
	// a disabled monitor cannot raise reset either
	assign O_SYS_RESET_REQ = I_LVM_RESET_REQ && O_LVM_ACTIVE && !cfg_q.lvm_reset_disable;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	sequence s_cfg_write(int bitpos, logic v);
		cfg_wr && (I_PWDATA[bitpos] == v);
	endsequence

	a_pin_follows_write: assert property (s_cfg_write(0, 1'b1) |=> O_PIN_CRYSTAL && O_MON_XTAL_RANGE)
		else $error("pin not switched to crystal after write");

	a_pin_gpio_write: assert property (s_cfg_write(0, 1'b0) |=> !O_PIN_CRYSTAL && !O_MON_XTAL_RANGE)
		else $error("pin not returned to gpio after write");

	a_stab_count_limit: assert property ($rose(stable_q) |->
		$past(stab_cnt_q) == (cfg_q.crystal_enable ? sysopt_pkg::STAB_XTAL_CYCLES : sysopt_pkg::STAB_EXT_CYCLES))
		else $error("stable flag rose at wrong count");

	a_stab_drop_off: assert property (!ext_gen_eff |=> !O_EXT_STABLE)
		else $error("stable flag held with generator off");

	a_stop_clocks_run: assert property (I_STOP_MODE && cfg_q.osc_run_in_stop && I_INT_CLK_EN |-> O_INT_CLK_EN)
		else $error("internal clock gated despite run-in-stop");

	a_stop_clocks_low: assert property (I_STOP_MODE && !cfg_q.osc_run_in_stop |-> !O_INT_CLK_EN && !O_EXT_CLK_EN)
		else $error("clock running in stop");

	a_reset_defaults: assert property ($rose(I_RESET_N) |-> cfg_q == 7'h00)
		else $error("options not cleared by reset");

	a_baud_source: assert property (O_BAUD_CLK_EN |-> (cfg_q.serial_clock_select ? O_BUS_CLK_EN : osc_tick))
		else $error("baud clock from wrong source");

	a_wdog_period: assert property (O_WDOG_TIMEOUT |->
		$past(osc_tick) && $past(wd_cnt_q) >= $past(wd_limit) - 18'h0_0001)
		else $error("watchdog timeout at wrong count");

	a_lvm_stop_mode: assert property (I_STOP_MODE |-> O_LVM_ACTIVE == (cfg_q.lvm_stop_enable && !cfg_q.lvm_power_down))
		else $error("monitor state in stop mode wrong");

	a_lvm_reset_block: assert property (cfg_q.lvm_reset_disable |-> !O_SYS_RESET_REQ)
		else $error("monitor reset not blocked");

	a_bus_quarter: assert property (O_BUS_CLK_EN |-> osc_tick ##1 !O_BUS_CLK_EN)
		else $error("bus clock not a quarter of oscillator");

	a_bus_spacing: assert property (O_BUS_CLK_EN |=> !O_BUS_CLK_EN [*1] ##0 bus_div_q == 2'h0)
		else $error("bus divider did not wrap");

	// gated clocks and the settle divider
	sequence s_gen_stopped;
		I_STOP_MODE && !cfg_q.osc_run_in_stop;
	endsequence

	sequence s_stab_step;
		O_EXT_CLK_EN && (stab_cnt_q < stab_limit);
	endsequence

	a_stop_ext_low: assert property (s_gen_stopped |-> !O_EXT_CLK_EN)
		else $error("external clock running in stop");

	a_stop_clears: assert property (s_gen_stopped |=> !O_EXT_STABLE && (stab_cnt_q == 13'h0000))
		else $error("settle state kept through stop");

	a_ext_gated_off: assert property (!I_EXT_GEN_ON |-> !O_EXT_CLK_EN)
		else $error("external tick with generator off");

	a_stab_step: assert property (s_stab_step |=> stab_cnt_q == $past(stab_cnt_q) + 13'h0001)
		else $error("settle divider missed a tick");

	a_stable_early: assert property (!O_EXT_STABLE && (stab_cnt_q < stab_limit) |=> !O_EXT_STABLE)
		else $error("stable flag set before the count");

	a_stable_sets: assert property (ext_gen_eff && (stab_cnt_q >= stab_limit) |=> O_EXT_STABLE)
		else $error("stable flag not set after the count");

	// oscillator output, bus and baud ticks
	a_osc_internal: assert property (!(I_SEL_EXT && O_EXT_STABLE) |-> (O_OSC_OUT_EN == O_INT_CLK_EN))
		else $error("oscillator tick not from internal clock");

	a_int_run: assert property (!I_STOP_MODE |-> (O_INT_CLK_EN == I_INT_CLK_EN))
		else $error("internal clock gated outside stop");

	a_bus_needs_tick: assert property (!osc_tick |-> !O_BUS_CLK_EN)
		else $error("bus tick without oscillator tick");

	a_baud_bus: assert property (cfg_q.serial_clock_select |-> (O_BAUD_CLK_EN == O_BUS_CLK_EN))
		else $error("baud tick not from bus clock");

	a_baud_osc: assert property (!cfg_q.serial_clock_select |-> (O_BAUD_CLK_EN == osc_tick))
		else $error("baud tick not from oscillator");

	a_baud_needs_tick: assert property (O_BAUD_CLK_EN |-> osc_tick)
		else $error("baud tick without oscillator tick");

	// watchdog
	a_wdog_single: assert property (O_WDOG_TIMEOUT |=> !O_WDOG_TIMEOUT)
		else $error("watchdog timeout longer than one cycle");

	a_wdog_service: assert property (I_WDOG_SERVICE |=> (wd_cnt_q == 18'h0_0000) && !O_WDOG_TIMEOUT)
		else $error("service did not clear the watchdog");

	a_wdog_quiet: assert property (!osc_tick |=> !O_WDOG_TIMEOUT)
		else $error("watchdog timeout without a tick");

	// low-voltage monitor
	a_lvm_awake: assert property (!I_STOP_MODE |-> O_LVM_ACTIVE)
		else $error("monitor off outside stop");

	a_lvm_gone: assert property (I_STOP_MODE && cfg_q.lvm_power_down |-> !O_LVM_ACTIVE)
		else $error("monitor on in stop despite power-down");

	a_lvm_reset_pass: assert property (I_LVM_RESET_REQ && O_LVM_ACTIVE && !cfg_q.lvm_reset_disable |-> O_SYS_RESET_REQ)
		else $error("monitor reset not passed on");

	// register bus
	a_cfg_hold: assert property (!cfg_wr |=> $stable(cfg_q))
		else $error("options changed without a write");

	a_pin_static: assert property (!cfg_wr |=> $stable(O_PIN_CRYSTAL))
		else $error("pin function changed without a write");

	a_cfg_load: assert property (cfg_wr |=>
		cfg_q == sysopt_pkg::cfg_t'($past(I_PWDATA[sysopt_pkg::CFG_WIDTH-1:0])))
		else $error("written options not loaded");

	a_apb_ready: assert property (O_PREADY)
		else $error("ready dropped");

	a_cfg_no_err: assert property (I_PSEL && I_PENABLE && addr_cfg |-> !O_PSLVERR)
		else $error("error answer on option register");

	a_stat_wr_err: assert property (I_PSEL && I_PENABLE && I_PWRITE && addr_stat |-> O_PSLVERR)
		else $error("status write not refused");

	a_stat_rd_ok: assert property (I_PSEL && I_PENABLE && !I_PWRITE && addr_stat |-> !O_PSLVERR)
		else $error("status read refused");

	a_unmapped_err: assert property (I_PSEL && I_PENABLE && !addr_cfg && !addr_stat |-> O_PSLVERR)
		else $error("unmapped access not refused");

	a_read_cfg: assert property (I_PSEL && !I_PENABLE && addr_cfg |=>
		O_PRDATA[sysopt_pkg::CFG_WIDTH-1:0] == $past(cfg_q) && O_PRDATA[31:sysopt_pkg::CFG_WIDTH] == '0)
		else $error("option read data wrong");

	a_read_stat: assert property (I_PSEL && !I_PENABLE && addr_stat |=>
		O_PRDATA[sysopt_pkg::STABLE_BIT] == $past(stable_q))
		else $error("status read data wrong");

	a_read_zero: assert property (I_PSEL && !I_PENABLE && !addr_cfg && !addr_stat |=> O_PRDATA == 32'h0000_0000)
		else $error("unmapped read not zero");

endmodule : sysopt_cfg

/* test/system_option_config_bits_bench.sv */
`timescale 1ns/1ps
module system_option_config_bits_bench;
	logic        clk, rst_n, psel, pen, pwr, stop, internal_clock, pin, gen, svc, lvq, run, div, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, xtal, mon, ien, een, stb, osc, bus, baud, wdt, lva, srq;
	logic [6:0]  cfg;
	logic [15:0] lf;
	int          n_errors, checked, k, n, nb, nd;

	// short watchdog limits keep the run brief
	sysopt_cfg #(.P_WDOG_SHORT(18'h0_0014), .P_WDOG_LONG(18'h0_0028)) i_dut (
		.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_STOP_MODE(stop), .I_INT_CLK_EN(internal_clock), .I_EXT_CLK_PIN(pin), .I_EXT_GEN_ON(gen),
		.I_SEL_EXT(1'b0), .I_WDOG_SERVICE(svc), .I_LVM_RESET_REQ(lvq), .O_PIN_CRYSTAL(xtal),
		.O_MON_XTAL_RANGE(mon), .O_INT_CLK_EN(ien), .O_EXT_CLK_EN(een), .O_EXT_STABLE(stb),
		.O_OSC_OUT_EN(osc), .O_BUS_CLK_EN(bus), .O_BAUD_CLK_EN(baud), .O_WDOG_TIMEOUT(wdt),
		.O_LVM_ACTIVE(lva), .O_SYS_RESET_REQ(srq));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// external pin toggles every second edge, slow enough for the synchroniser
	always @(posedge clk) begin
		div <= ~div;
		if (run && div)
			pin <= ~pin;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	function automatic int wd_limit(input logic s);
		return s ? 20 : 40;
	endfunction : wd_limit

	function automatic int stab_len(input logic x);
		return x ? 4096 : 16;
	endfunction : stab_len

	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic hang();
		n_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		give_verdict();
	endtask : hang

	// one apb transfer, request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				rd = prdata;
				err = pslverr;
				psel <= 1'b0;
				pen <= 1'b0;
				return;
			end
		end
		hang();
	endtask : apb

	initial begin
		{psel, pen, pwr, stop, pin, gen, svc, lvq, run, div} = '0;
		paddr = 8'h00; pwdata = 32'h0000_0000; internal_clock = 1'b1; rst_n = 1'b0;
		lf = 16'h88B3; n_errors = 0; checked = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(xtal, 0);
		chk(mon, 0);
		apb(1'b0, sysopt_pkg::CFG_OFFSET, 32'h0);
		chk(rd, 32'h0);
		// random option words, with all-ones and all-zeros as corners
		for (k = 0; k < 12; k++) begin
			lf = lfsr(lf);
			cfg = (k == 0) ? 7'h7F : (k == 1) ? 7'h00 : lf[6:0];
			apb(1'b1, sysopt_pkg::CFG_OFFSET, {25'h0, cfg});
			chk(err, 0);
			apb(1'b0, sysopt_pkg::CFG_OFFSET, 32'h0);
			chk(rd, {25'h0, cfg});
			chk(xtal, cfg[sysopt_pkg::XTAL_BIT]);
			chk(mon, cfg[sysopt_pkg::XTAL_BIT]);
			nb = 0; nd = 0;
			repeat (40) begin
				@(negedge clk);
				nb += int'(bus === 1'b1);
				nd += int'(baud === 1'b1);
			end
			chk(nb, 10);
			chk(nd, cfg[sysopt_pkg::BAUDSRC_BIT] ? 10 : 40);
			@(posedge clk);
			lvq <= 1'b1;
			@(negedge clk);
			if (!cfg[sysopt_pkg::LVMPWRD_BIT])
				chk(srq, !cfg[sysopt_pkg::LVMRSTD_BIT]);
			@(posedge clk);
			stop <= 1'b1;
			@(negedge clk);
			chk(ien, cfg[sysopt_pkg::OSCSTOP_BIT]);
			chk(lva, cfg[sysopt_pkg::LVMSTOP_BIT] & !cfg[sysopt_pkg::LVMPWRD_BIT]);
			chk(srq, lva & !cfg[sysopt_pkg::LVMRSTD_BIT]);
			@(posedge clk);
			stop <= 1'b0; lvq <= 1'b0; svc <= 1'b1;
			@(posedge clk);
			svc <= 1'b0;
			n = 0;
			for (int i = 0; i < 200 && wdt !== 1'b1; i++) begin
				@(negedge clk);
				if (wdt !== 1'b1)
					n += int'(osc === 1'b1);
			end
			chk(n, wd_limit(cfg[sysopt_pkg::WDRATE_BIT]));
		end
		// stabilisation count without and with a crystal, then a stop restart
		for (k = 0; k < 2; k++) begin
			apb(1'b1, sysopt_pkg::CFG_OFFSET, {31'h0, k[0]});
			gen <= 1'b1; run <= 1'b1;
			// second pass counts again after leaving stop
			for (int j = 0; j < 2; j++) begin
				n = 0;
				for (int i = 0; i < 20000 && stb !== 1'b1; i++) begin
					@(negedge clk);
					if (stb !== 1'b1)
						n += int'(een === 1'b1);
				end
				chk(n, stab_len(k[0]));
				apb(1'b0, sysopt_pkg::STAT_OFFSET, 32'h0);
				chk(rd[sysopt_pkg::STABLE_BIT], 1);
				@(posedge clk);
				stop <= 1'b1;
				repeat (3) @(negedge clk);
				chk({stb, een}, 0);
				@(posedge clk);
				stop <= 1'b0;
			end
			@(posedge clk);
			{gen, run} <= '0;
		end
		// status writes and unmapped places are refused
		apb(1'b1, sysopt_pkg::STAT_OFFSET, 32'hFFFF_FFFF);
		chk(err, 1);
		apb(1'b0, 8'h08, 32'h0);
		chk(err, 1);
		chk(rd, 32'h0);
		give_verdict();
	end
endmodule : system_option_config_bits_bench
